// >>> common/ttg_pkg.sv
package ttg_pkg;
  // register byte offsets
  localparam logic [6:0] G_NUM_PKT = 7'h00, G_CONFIG = 7'h04, G_SEED_LO = 7'h08;
  localparam logic [6:0] G_SEED_HI = 7'h0C, G_SA_LO = 7'h10, G_SA_HI = 7'h14;
  localparam logic [6:0] G_DA_LO = 7'h18, G_DA_HI = 7'h1C, G_OPER = 7'h20, G_TX_CNT = 7'h24;
  localparam logic [6:0] M_NUM_PKT = 7'h40, M_OK = 7'h44, M_ERR = 7'h48, M_BYTE_LO = 7'h4C;
  localparam logic [6:0] M_BYTE_HI = 7'h50, M_CYC_LO = 7'h54, M_CYC_HI = 7'h58, M_CTRL = 7'h5C;
  // field positions
  localparam int CFG_LEN_SEL = 0, CFG_LEN_LSB = 1, CFG_LEN_MSB = 14, CFG_RAND_DATA = 15;
  localparam int OP_START = 0, OP_STOP = 1, OP_DONE = 2;
  localparam int MC_START = 0, MC_STOP = 1, MC_DONE = 2, MC_EN = 3;
  // frame layout and length limits
  localparam logic [13:0] LEN_MIN = 14'h0018, LEN_FIX_MAX = 14'h2580, LEN_RAND_MAX = 14'h05EE;
  localparam logic [10:0] LEN_RAND_SPAN = 11'h5D6, LEN_RAND_FOLD = 11'h400;
  localparam logic [13:0] DA_END = 14'h0006, SA_END = 14'h000C, HDR_LEN = 14'h000E;
  localparam logic [13:0] SEQ_END = 14'h0010, CRC_BYTES = 14'h0004;
  // checksum and prbs
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF, CRC_POLY = 32'hEDB88320;
  localparam int PRBS_TAP_A = 22, PRBS_TAP_B = 17;
  localparam logic [22:0] PRBS_ONE = 23'h000001;

  typedef struct packed {
    logic [7:0] data;
    logic       sop;
    logic       eop;
    logic       valid;
  } ttg_stream_t;

  typedef enum logic [1:0] {G_IDLE, G_FILL, G_SEND} ttg_gen_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdat;
    logic [31:0] numPkt;
    logic [15:0] cfg;
    logic [31:0] seedLo;
    logic [15:0] seedHi;
    logic [31:0] saLo;
    logic [15:0] saHi;
    logic [31:0] daLo;
    logic [15:0] daHi;
    logic        stopReq;
    logic        done;
    logic [31:0] txCnt;
    ttg_gen_t    gst;
    logic [15:0] seq;
    logic [13:0] len;
    logic [13:0] idx;
    logic [13:0] rdIdx;
    logic [22:0] prbs;
    logic [7:0]  inc;
    logic [31:0] crc;
    ttg_stream_t tx;
    logic        rxRdy;
    logic [31:0] mNum;
    logic [31:0] okCnt;
    logic [31:0] errCnt;
    logic [63:0] bytes;
    logic [63:0] cycles;
    logic [31:0] byteSnap;
    logic        monEn;
    logic        monStop;
    logic        monDone;
    logic        running;
    logic        inPkt;
    logic [2:0]  rcnt;
    logic [31:0] win;
    logic [31:0] rcrc;
  } ttg_state_t;
endpackage : ttg_pkg

// >>> hdl/ttg_crc32.sv
// one-byte update of the reflected 32-bit frame checksum
module ttg_crc32 import ttg_pkg::*; (
  input  wire logic [31:0] crcIn,
  input  wire logic [7:0]  dataIn,
  output logic      [31:0] crcOut
);
  // bitwise lfsr step, lsb first
  always_comb begin
    crcOut = crcIn ^ {24'h000000, dataIn};
    for (int b = 0; b < 8; b++) begin
      crcOut = crcOut[0] ? ((crcOut >> 1) ^ CRC_POLY) : (crcOut >> 1);
    end
  end
endmodule // ttg_crc32

// >>> hdl/ttg_top.sv
// test-traffic generator and monitor with a classic wishbone register slave
module ttg_top import ttg_pkg::*; #(
  parameter int RAM_DEPTH = 16384
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  input  wire logic        wbWe,
  input  wire logic [6:0]  wbAdr,
  input  wire logic [3:0]  wbSel,
  input  wire logic [31:0] wbDatW,
  output logic      [31:0] wbDatR,
  output logic             wbAck,
  output ttg_stream_t      txStream,
  input  wire logic        txReady,
  input  ttg_stream_t      rxStream,
  output logic             rxReady
);
  ttg_state_t  s;
  ttg_state_t  n;
  logic [7:0]  ram [RAM_DEPTH];
  logic [7:0]  ramQ;
  logic [7:0]  genByte;
  logic [7:0]  sendByte;
  logic [31:0] txCrcNext;
  logic [31:0] rxCrcNext;
  logic [31:0] rdMux;
  logic [31:0] wNew;
  logic [47:0] daAddr;
  logic [47:0] saAddr;
  logic [13:0] payLen;
  logic [13:0] fixLen;
  logic [10:0] rl;
  logic [2:0]  k;
  logic [31:0] c;
  logic [31:0] w;
  logic [1:0]  crcSel;
  logic        wbReq;
  logic        wbWr;
  logic [6:0]  adrW;
  logic        genStart;
  logic        genStop;
  logic        monStart;
  logic        monStop;
  logic        txTake;
  logic        rxByte;
  logic        newFrame;
  logic        good;

  // advance the 2^23-1 sequence by one byte
  function automatic logic [22:0] prbs_step8(input logic [22:0] v);
    logic [22:0] t;
    t = v;
    for (int i = 0; i < 8; i++) begin
      t = {t[21:0], t[PRBS_TAP_A] ^ t[PRBS_TAP_B]};
    end
    return t;
  endfunction

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[8*b +: 8] = d[8*b +: 8];
    end
    return r;
  endfunction

  // pick byte k of a 48-bit address, most significant first
  function automatic logic [7:0] addr_byte(input logic [47:0] a, input logic [13:0] kk);
    return a[8*(5 - kk[2:0]) +: 8];
  endfunction

  ttg_crc32 u_txCrc (
    .crcIn  (s.crc),
    .dataIn (genByte),
    .crcOut (txCrcNext)
  );

  ttg_crc32 u_rxCrc (
    .crcIn  (s.rcrc),
    .dataIn (s.win[7:0]),
    .crcOut (rxCrcNext)
  );

  // bus strobes and decoded commands
  assign wbReq    = wbCyc && wbStb;
  assign wbWr     = wbReq && wbWe && s.ack;
  assign adrW     = {wbAdr[6:2], 2'b00};
  assign genStart = wbWr && adrW == G_OPER && wbSel[0] && wbDatW[OP_START];
  assign genStop  = wbWr && adrW == G_OPER && wbSel[0] && wbDatW[OP_STOP];
  assign monStart = wbWr && adrW == M_CTRL && wbSel[0] && wbDatW[MC_START];
  assign monStop  = wbWr && adrW == M_CTRL && wbSel[0] && wbDatW[MC_STOP];
  assign txTake   = s.tx.valid && txReady;
  assign rxByte   = rxStream.valid && s.rxRdy && s.monEn && (s.inPkt || rxStream.sop);
  assign daAddr   = {s.daHi, s.daLo};
  assign saAddr   = {s.saHi, s.saLo};
  assign payLen   = s.len - HDR_LEN;
  assign wNew     = wmerge(rdMux, wbDatW, wbSel);

  // delay line: frame held while its checksum is built
  always_ff @(posedge clk) begin
    if (s.gst == G_FILL) ram[s.idx] <= genByte;
  end
  assign ramQ = ram[s.rdIdx];

  // clamp of the fixed length into its legal span
  always_comb begin
    fixLen = s.cfg[CFG_LEN_MSB:CFG_LEN_LSB];
    if (fixLen < LEN_MIN) fixLen = LEN_MIN;
    else if (fixLen > LEN_FIX_MAX) fixLen = LEN_FIX_MAX;
  end

  // byte produced while filling the delay line
  always_comb begin
    if (s.idx < DA_END) genByte = addr_byte(daAddr, s.idx);
    else if (s.idx < SA_END) genByte = addr_byte(saAddr, s.idx - DA_END);
    else if (s.idx == SA_END) genByte = {2'b00, payLen[13:8]};
    else if (s.idx < HDR_LEN) genByte = payLen[7:0];
    else if (s.idx == HDR_LEN) genByte = s.seq[15:8];
    else if (s.idx < SEQ_END) genByte = s.seq[7:0];
    else if (s.cfg[CFG_RAND_DATA]) genByte = s.prbs[7:0];
    else genByte = s.inc;
  end

  // output byte: stored frame, tail replaced by the checksum
  always_comb begin
    crcSel = 2'(s.rdIdx - (s.len - CRC_BYTES));
    if (s.rdIdx >= s.len - CRC_BYTES) sendByte = s.crc[8*crcSel +: 8];
    else sendByte = ramQ;
  end

  // read mux, also the old value for byte-lane writes
  always_comb begin
    if (adrW == G_NUM_PKT) rdMux = s.numPkt;
    else if (adrW == G_CONFIG) rdMux = {16'h0000, s.cfg};
    else if (adrW == G_SEED_LO) rdMux = s.seedLo;
    else if (adrW == G_SEED_HI) rdMux = {16'h0000, s.seedHi};
    else if (adrW == G_SA_LO) rdMux = s.saLo;
    else if (adrW == G_SA_HI) rdMux = {16'h0000, s.saHi};
    else if (adrW == G_DA_LO) rdMux = s.daLo;
    else if (adrW == G_DA_HI) rdMux = {16'h0000, s.daHi};
    else if (adrW == G_OPER) rdMux = {29'h00000000, s.done, s.stopReq, 1'b0};
    else if (adrW == G_TX_CNT) rdMux = s.txCnt;
    else if (adrW == M_NUM_PKT) rdMux = s.mNum;
    else if (adrW == M_OK) rdMux = s.okCnt;
    else if (adrW == M_ERR) rdMux = s.errCnt;
    else if (adrW == M_BYTE_LO) rdMux = s.bytes[31:0];
    else if (adrW == M_BYTE_HI) rdMux = s.byteSnap;
    else if (adrW == M_CYC_LO) rdMux = s.cycles[31:0];
    else if (adrW == M_CYC_HI) rdMux = s.cycles[63:32];
    else if (adrW == M_CTRL) rdMux = {28'h0000000, s.monEn, s.monDone, s.monStop, 1'b0};
    else rdMux = 32'h00000000;
  end

  // next-state logic for bus, generator and monitor
  always_comb begin
    n        = s;
    newFrame = 1'b0;
    rl       = 11'h000;
    k        = 3'h0;
    c        = CRC_INIT;
    w        = 32'h00000000;
    good     = 1'b0;
    n.rxRdy  = 1'b1;
    // single-wait-state slave answer
    n.ack = wbReq && !s.ack;
    if (n.ack) n.rdat = rdMux;
    if (n.ack && !wbWe && adrW == M_BYTE_LO) n.byteSnap = s.bytes[63:32];
    if (wbWr) begin
      if (adrW == G_NUM_PKT) n.numPkt = wNew;
      else if (adrW == G_CONFIG) n.cfg = wNew[15:0];
      else if (adrW == G_SEED_LO) n.seedLo = wNew;
      else if (adrW == G_SEED_HI) n.seedHi = wNew[15:0];
      else if (adrW == G_SA_LO) n.saLo = wNew;
      else if (adrW == G_SA_HI) n.saHi = wNew[15:0];
      else if (adrW == G_DA_LO) n.daLo = wNew;
      else if (adrW == G_DA_HI) n.daHi = wNew[15:0];
      else if (adrW == M_NUM_PKT) n.mNum = wNew;
    end
    // frame handed to the transmit side
    if (txTake) begin
      n.tx.valid = 1'b0;
      if (s.tx.eop) begin
        n.txCnt = s.txCnt + 32'h00000001;
        n.seq   = s.seq + 16'h0001;
      end
    end
    case (s.gst)
      G_IDLE: begin
      end
      G_FILL: begin
        n.idx = s.idx + 14'h0001;
        n.crc = txCrcNext;
        if (s.idx >= SEQ_END) begin
          if (s.cfg[CFG_RAND_DATA]) n.prbs = prbs_step8(s.prbs);
          else n.inc = s.inc + 8'h01;
        end
        if (s.idx == s.len - CRC_BYTES - 14'h0001) begin
          n.gst   = G_SEND;
          n.rdIdx = 14'h0000;
          n.crc   = ~txCrcNext;
        end
      end
      G_SEND: begin
        if (!s.tx.valid || txReady) begin
          if (s.rdIdx != s.len) begin
            n.tx.data  = sendByte;
            n.tx.sop   = s.rdIdx == 14'h0000;
            n.tx.eop   = s.rdIdx == s.len - 14'h0001;
            n.tx.valid = 1'b1;
            n.rdIdx    = s.rdIdx + 14'h0001;
          end else if (s.stopReq || n.txCnt >= s.numPkt) begin
            n.gst  = G_IDLE;
            n.done = n.txCnt >= s.numPkt;
          end else begin
            newFrame = 1'b1;
          end
        end
      end
      default: n.gst = G_IDLE;
    endcase
    if (genStop) n.stopReq = 1'b1;
    // soft reset of the generator
    if (genStart) begin
      n.txCnt    = 32'h00000000;
      n.seq      = 16'h0000;
      n.stopReq  = 1'b0;
      n.tx.valid = 1'b0;
      n.prbs     = (s.seedLo[22:0] == 23'h000000) ? PRBS_ONE : s.seedLo[22:0];
      n.done     = s.numPkt == 32'h00000000;
      n.gst      = G_IDLE;
      newFrame   = s.numPkt != 32'h00000000;
    end
    // length pick and setup of the next frame
    if (newFrame) begin
      rl = n.prbs[10:0];
      if (rl > LEN_RAND_SPAN) rl = rl - LEN_RAND_FOLD;
      n.len = s.cfg[CFG_LEN_SEL] ? LEN_MIN + {3'b000, rl} : fixLen;
      if (s.cfg[CFG_LEN_SEL]) n.prbs = prbs_step8(n.prbs);
      n.gst = G_FILL;
      n.idx = 14'h0000;
      n.crc = CRC_INIT;
      n.inc = 8'h00;
    end
    // monitor: stream carries header, payload and check sequence
    if (s.running || rxByte) n.cycles = s.cycles + 64'h0000000000000001;
    if (rxByte) begin
      n.bytes   = s.bytes + 64'h0000000000000001;
      n.running = 1'b1;
      k         = rxStream.sop ? 3'h0 : s.rcnt;
      c         = rxStream.sop ? CRC_INIT : ((s.rcnt == 3'h4) ? rxCrcNext : s.rcrc);
      w         = {rxStream.data, (rxStream.sop ? 24'h000000 : s.win[31:8])};
      n.win     = w;
      n.rcrc    = c;
      n.rcnt    = (k == 3'h4) ? 3'h4 : k + 3'h1;
      n.inPkt   = !rxStream.eop;
      if (rxStream.eop) begin
        good = (k >= 3'h3) && (~c == w);
        if (good) n.okCnt = s.okCnt + 32'h00000001;
        else n.errCnt = s.errCnt + 32'h00000001;
        if (n.okCnt + n.errCnt == s.mNum) begin
          n.monDone = 1'b1;
          n.monEn   = 1'b0;
          n.running = 1'b0;
        end
      end
    end
    if (monStop) begin
      n.monEn   = 1'b0;
      n.monStop = 1'b1;
      n.running = 1'b0;
    end
    if (monStart) begin
      n.okCnt   = 32'h00000000;
      n.errCnt  = 32'h00000000;
      n.bytes   = 64'h0000000000000000;
      n.cycles  = 64'h0000000000000000;
      n.monEn   = 1'b1;
      n.monStop = 1'b0;
      n.monDone = 1'b0;
      n.running = 1'b0;
      n.inPkt   = 1'b0;
    end
  end

  // state register, synchronous reset
  always_ff @(posedge clk) begin
    if (!rstn) s <= '0;
    else s <= n;
  end

  assign wbDatR   = s.rdat;
  assign wbAck    = s.ack;
  assign txStream = s.tx;
  assign rxReady  = s.rxRdy;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence sFrameEnd;
    txTake && s.tx.eop && !genStart;
  endsequence

  a_ack_pulse: assert property (s.ack |=> !s.ack)
    else $error("ack held two cycles");
  a_stop_halt: assert property (sFrameEnd ##0 s.stopReq |=> s.gst == G_IDLE)
    else $error("generator went on after stop");
  a_len_bounds: assert property (s.gst == G_FILL |-> s.len >= LEN_MIN && s.len <= LEN_FIX_MAX)
    else $error("frame length out of span");
  a_rand_len: assert property (newFrame && s.cfg[CFG_LEN_SEL] && !wbWr |=> s.len <= LEN_RAND_MAX)
    else $error("random length above limit");
  a_da_first: assert property (txTake && s.tx.sop |-> s.tx.data == s.daHi[15:8])
    else $error("first byte is not destination");
  a_seq_step: assert property (sFrameEnd |=> s.seq == $past(s.seq) + 16'h0001)
    else $error("sequence number did not step");
  a_start_clear: assert property (genStart |=> s.txCnt == 32'h0 && !s.stopReq ##1 !s.ack)
    else $error("start did not clear generator");
  a_mon_freeze: assert property (!s.monEn && !monStart |=> $stable(s.bytes) && $stable(s.okCnt))
    else $error("counters moved while disabled");
  a_mon_verdict: assert property (rxByte && rxStream.eop && !monStart
                                  |=> s.okCnt + s.errCnt == $past(s.okCnt + s.errCnt) + 32'h1)
    else $error("packet not counted once");
endmodule // ttg_top

// >>> test/ttg_mac_model.sv
// behavioural mac fifo pair: takes generated frames and loops them back
module ttg_mac_model import ttg_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire ttg_stream_t txStream,
  output ttg_stream_t      rxStream,
  output logic             txReady,
  input  wire logic        rxReady,
  input  wire logic        slow,
  input  wire logic        corrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  cap[$];
  logic [7:0]  last[$];
  logic [7:0]  rep[$];
  int          lens[$];
  ttg_stream_t prev     = '0;
  logic        rdyPrev  = 1'b0;
  int          nFrames  = 0;
  int          tick     = 0;
  int          pos      = 0;
  int          firstSop = -1;
  int          lastEop  = 0;
  int          errs     = 0;
  initial txReady = 1'b0;
  initial rxStream = '0;
  // tx side refuses every other cycle when slow; a refused byte must stand unchanged
  always @(posedge clk) begin
    tick++;
    if (rstn && prev.valid && !rdyPrev && txStream !== prev) errs++;
    prev = txStream;
    rdyPrev = txReady;
    if (txStream.valid && txReady) begin
      if (txStream.sop) cap.delete();
      cap.push_back(txStream.data);
      if (txStream.eop) begin
        nFrames++;
        last = cap;
        if (corrupt) cap[16] = ~cap[16];
        // frames queue up for replay; check sequence still in place
        foreach (cap[i]) rep.push_back(cap[i]);
        lens.push_back(cap.size());
      end
    end
    txReady <= rstn && !(slow && tick[0]);
    // rx side replays the captured frame one byte per cycle
    if (rxStream.valid && rxReady) begin
      pos++;
      if (rxStream.eop) begin
        lastEop = tick;
        pos = 0;
        for (int i = 0; i < lens[0]; i++) rep.delete(0);
        lens.delete(0);
      end
    end
    if (rstn && lens.size() != 0) begin
      if (pos == 0 && firstSop < 0) firstSop = tick;
      rxStream <= '{data: rep[pos], sop: pos == 0, eop: pos == lens[0] - 1, valid: 1'b1};
    end else begin
      rxStream <= '{data: ~rxStream.data, sop: 1'b0, eop: 1'b0, valid: 1'b0};
    end
  end
endmodule // ttg_mac_model

// >>> test/tb.sv
// self-checking bench for the traffic generator and monitor
module tb import ttg_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [6:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wd;
    logic [31:0] rd;
  } ttg_row_t;
  localparam logic [47:0] DA = 48'h0A1B2C3D4E5F;
  localparam logic [47:0] SA = 48'h102030405060;
  logic        clk       = 1'b0;
  logic        rstn      = 1'b0;
  logic        wbCyc     = 1'b0;
  logic        wbStb     = 1'b0;
  logic        wbWe      = 1'b0;
  logic [6:0]  wbAdr     = 7'h00;
  logic [3:0]  wbSel     = 4'h0;
  logic [31:0] wbDatW    = 32'h0;
  logic [31:0] wbDatR;
  logic        wbAck;
  logic        txReady;
  logic        rxReady;
  logic        slow      = 1'b0;
  logic        corrupt   = 1'b0;
  ttg_stream_t txStream;
  ttg_stream_t rxStream;
  int          errTotal  = 0;
  int          nCompared = 0;
  logic [22:0] pr        = 23'h000000;
  // address, byte enables, write data, expected read back
  ttg_row_t    rows[13] = '{
    '{G_NUM_PKT, 4'h3, 32'hA5A50F0F, 32'h00000F0F}, '{G_CONFIG, 4'hF, 32'hFFFFFFFF, 32'h0000FFFF},
    '{G_SEED_LO, 4'hF, 32'h12345678, 32'h12345678}, '{G_SEED_HI, 4'hF, 32'hFFFFABCD, 32'h0000ABCD},
    '{G_SA_LO, 4'hC, 32'h87654321, 32'h87650000}, '{G_SA_HI, 4'hF, 32'h0000BEEF, 32'h0000BEEF},
    '{G_DA_LO, 4'hF, 32'hCAFE0001, 32'hCAFE0001}, '{G_DA_HI, 4'hF, 32'hFFFF1234, 32'h00001234},
    '{G_TX_CNT, 4'hF, 32'hFFFFFFFF, 32'h0}, '{M_NUM_PKT, 4'hF, 32'h00000005, 32'h00000005},
    '{M_ERR, 4'hF, 32'hFFFFFFFF, 32'h0}, '{M_CYC_HI, 4'hF, 32'hFFFFFFFF, 32'h0},
    '{7'h30, 4'hF, 32'hFFFFFFFF, 32'h0}};

  ttg_top u_dut (.clk(clk), .rstn(rstn), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck),
    .txStream(txStream), .txReady(txReady), .rxStream(rxStream), .rxReady(rxReady));
  ttg_mac_model u_mac (.clk(clk), .rstn(rstn), .txStream(txStream), .rxStream(rxStream),
    .txReady(txReady), .rxReady(rxReady), .slow(slow), .corrupt(corrupt));

  // 25 MHz clock
  always #20 clk = ~clk;

  task automatic results;
    if (errTotal == 0 && nCompared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic hang(input string nm);
    errTotal++;
    $display("[FAIL] %s expected completion seen timeout", nm);
    results();
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    nCompared++;
    if (s !== e) begin
      errTotal++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one classic wishbone cycle, held until ack is sampled high
  task automatic wb(input logic [6:0] a, input logic we, input logic [3:0] sl,
                    input logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbSel <= sl;
    wbDatW <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wbAck !== 1'b1 && k < 50);
    if (k >= 50) hang("bus ack");
    q = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(a, 1'b1, 4'hF, d, q);
  endtask
  task automatic rdc(input logic [6:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    wb(a, 1'b0, 4'hF, 32'h0, q);
    chk(nm, e, q);
  endtask
  task automatic poll(input logic [6:0] a, input int b);
    logic [31:0] q;
    int k;
    k = 0;
    q = '0;
    while (q[b] !== 1'b1 && k < 3000) begin
      wb(a, 1'b0, 4'hF, 32'h0, q);
      k++;
    end
    if (k >= 3000) hang("status bit");
  endtask
  task automatic go(input logic [31:0] cfg, input logic [31:0] n);
    wr(G_CONFIG, cfg);
    wr(G_NUM_PKT, n);
    wr(G_OPER, 32'h1);
  endtask
  task automatic wait_for(input int n);
    int k;
    k = 0;
    while (u_mac.nFrames < n && k < 40000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 40000) hang("frame");
  endtask
  task automatic wait_rx;
    int k;
    k = 0;
    while (u_mac.rep.size() != 0 && k < 20000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 20000) hang("loopback");
  endtask
  // reference 2^23-1 sequence, eight steps per byte
  function automatic logic [22:0] nx8(input logic [22:0] v);
    for (int i = 0; i < 8; i++) v = {v[21:0], v[PRBS_TAP_A] ^ v[PRBS_TAP_B]};
    return v;
  endfunction
  // compares the last captured frame with the layout built from the settings
  task automatic chk_frame(input int len, input logic [15:0] seq, input bit inc);
    logic [31:0] c;
    logic [15:0] lt;
    logic [7:0]  e;
    c = CRC_INIT;
    lt = 16'(len - 14);
    chk("frame length", 32'(len), 32'(u_mac.last.size()));
    for (int i = 0; i < len - 4; i++) begin
      c ^= {24'h0, u_mac.last[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    c = ~c;
    for (int i = 0; i < len; i++) begin
      e = i < 6 ? DA[47 - 8 * i -: 8] : i < 12 ? SA[95 - 8 * i -: 8] : i < 14 ? lt[111 - 8 * i -: 8]
        : i < 16 ? seq[127 - 8 * i -: 8] : i >= len - 4 ? c[8 * (i - len + 4) +: 8]
        : inc ? 8'(i - 16) : pr[7:0];
      chk("frame byte", {24'h0, e}, {24'h0, u_mac.last[i]});
      if (!inc && i >= 16 && i < len - 4) pr = nx8(pr);
    end
  endtask

  // main sequence
  initial begin
    logic [31:0] q;
    int b;
    logic [10:0] rl;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    chk("rxReady in reset", 32'h0, {31'h0, rxReady});
    @(posedge clk);
    @(negedge clk);
    chk("rxReady after reset", 32'h1, {31'h0, rxReady});
    foreach (rows[r]) begin
      rdc(rows[r].adr, 32'h0, "reset value");
      wb(rows[r].adr, 1'b1, rows[r].sel, rows[r].wd, q);
      rdc(rows[r].adr, rows[r].rd, "register read back");
    end
    // two short frames with the far side stalling, monitor counting both
    wr(G_DA_HI, {16'h0, DA[47:32]});
    wr(G_DA_LO, DA[31:0]);
    wr(G_SA_HI, {16'h0, SA[47:32]});
    wr(G_SA_LO, SA[31:0]);
    wr(M_NUM_PKT, 32'h2);
    wr(M_CTRL, 32'h1);
    slow <= 1'b1;
    u_mac.firstSop = -1;
    b = u_mac.nFrames;
    go(32'h18 << CFG_LEN_LSB, 32'h2);
    wait_for(b + 1);
    chk_frame(24, 16'h0, 1'b1);
    wait_for(b + 2);
    chk_frame(24, 16'h1, 1'b1);
    poll(G_OPER, OP_DONE);
    rdc(G_TX_CNT, 32'h2, "tx count");
    poll(M_CTRL, MC_DONE);
    rdc(M_OK, 32'h2, "good count");
    rdc(M_ERR, 32'h0, "bad count");
    rdc(M_BYTE_LO, 32'h30, "byte count");
    rdc(M_BYTE_HI, 32'h0, "byte count high");
    rdc(M_CYC_LO, 32'(u_mac.lastEop - u_mac.firstSop), "cycle count");
    // corrupted frames: ignored while idle, counted bad once started; a clean frame after stop leaves the counters frozen
    slow <= 1'b0;
    corrupt <= 1'b1;
    b = u_mac.nFrames;
    go(32'h1E << CFG_LEN_LSB, 32'h1);
    wait_for(b + 1);
    wait_rx();
    rdc(M_OK, 32'h2, "good while idle");
    rdc(M_ERR, 32'h0, "bad while idle");
    wr(M_NUM_PKT, 32'h0);
    wr(M_CTRL, 32'h1);
    rdc(M_OK, 32'h0, "good after start");
    rdc(M_BYTE_LO, 32'h0, "bytes after start");
    wr(G_OPER, 32'h1);
    wait_for(b + 2);
    wait_rx();
    rdc(M_ERR, 32'h1, "bad count");
    rdc(M_OK, 32'h0, "good count");
    rdc(M_BYTE_LO, 32'h1E, "byte count");
    wr(M_CTRL, 32'h2);
    corrupt <= 1'b0;
    wr(G_OPER, 32'h1);
    wait_for(b + 3);
    wait_rx();
    rdc(M_OK, 32'h0, "good after stop");
    rdc(M_BYTE_LO, 32'h1E, "bytes after stop");
    rdc(M_CTRL, 32'h2, "monitor status");
    // generator stop mid run, then restart
    b = u_mac.nFrames;
    go(32'h28 << CFG_LEN_LSB, 32'h3E8);
    wait_for(b + 1);
    wr(G_OPER, 32'h2);
    wait_for(b + 2);
    repeat (300) @(posedge clk);
    chk("frames after stop", 32'(b + 2), 32'(u_mac.nFrames));
    rdc(G_TX_CNT, 32'h2, "tx count at stop");
    rdc(G_OPER, 32'h2, "stopped status");
    wr(G_NUM_PKT, 32'h1);
    wr(G_OPER, 32'h1);
    rdc(G_TX_CNT, 32'h0, "count after start");
    rdc(G_OPER, 32'h0, "status after start");
    wait_for(b + 3);
    chk_frame(40, 16'h0, 1'b1);
    poll(G_OPER, OP_DONE);
    // random length and payload, verified by the monitor
    wr(G_SEED_LO, 32'h0055AA11);
    pr = 23'h55AA11;
    wr(M_NUM_PKT, 32'h3);
    wr(M_CTRL, 32'h1);
    b = u_mac.nFrames;
    go(32'h8001, 32'h3);
    for (int f = 0; f < 3; f++) begin
      wait_for(b + f + 1);
      rl = pr[10:0];
      if (rl > LEN_RAND_SPAN) rl = rl - LEN_RAND_FOLD;
      pr = nx8(pr);
      chk("random length", 32'h1, 32'(u_mac.last.size() inside {[24:1518]}));
      chk_frame(24 + rl, 16'(f), 1'b0);
    end
    poll(M_CTRL, MC_DONE);
    rdc(M_OK, 32'h3, "good random frames");
    // longest fixed frame
    b = u_mac.nFrames;
    go(32'h2580 << CFG_LEN_LSB, 32'h1);
    wait_for(b + 1);
    chk_frame(9600, 16'h0, 1'b1);
    // hardware reset in mid run: outputs and registers return to zero
    b = u_mac.nFrames;
    go(32'h18 << CFG_LEN_LSB, 32'h4);
    wait_for(b + 1);
    repeat (22) @(posedge clk);
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    chk("stream in reset", 32'h0, {31'h0, txStream.valid});
    chk("ack in reset", 32'h0, {31'h0, wbAck});
    chk("read data in reset", 32'h0, wbDatR);
    chk("rxReady mid reset", 32'h0, {31'h0, rxReady});
    rstn <= 1'b1;
    b = u_mac.nFrames;
    rdc(G_CONFIG, 32'h0, "config after reset");
    rdc(G_TX_CNT, 32'h0, "tx count after reset");
    wr(G_OPER, 32'h1);
    rdc(G_OPER, 32'h4, "done with no packets");
    repeat (100) @(posedge clk);
    chk("frames after reset", 32'(b), 32'(u_mac.nFrames));
    chk("refused byte held", 32'h0, 32'(u_mac.errs));
    results();
  end
endmodule // tb
